// *** design/monitoring_case_supervisor.sv ***
// Safety output supervisor: detection filter, case sequence check, park and stand-by
`timescale 1ns/1ps

// Summary of operation
// - Consecutive-detection count is held between 2 and 16 scans.
// - Each monitoring case keeps its own count; the active case's count applies.
// - Arbitrary mode accepts a change to any defined case.
// - Unique mode accepts a change only to the one configured successor.
// - Alternative mode accepts a change only to one of two successors.
// - Park or stand-by forces safety outputs OFF and the emitter off.
// - Shared outputs go OFF when either linked scanner parks or stands by.
// - Separate outputs ignore the partner scanner's park or stand-by.
// - Park is entered when the active case is marked as park case.
// - Leaving park waits the response time before the new case acts.
// - The dedicated stand-by input, when high, puts the device in stand-by.
// - A stand-by command from the safety link also enters stand-by.
// - Stand-by occupies no monitoring case slot.
// - Detection turns outputs OFF only after the configured run of consecutive detections.
// - Undefined case selection drives the safety outputs OFF.
module monitoring_case_supervisor
  import supervisor_pkg::*;
#(
  parameter int PARK_EXIT_CYCLES = PARK_EXIT_CYC
)(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire reg_req_s          reg_req,
  output logic [DATA_W-1:0]      reg_rdata,
  input  wire logic              scan_strobe,
  input  wire logic              scan_hit,
  input  wire logic              case_valid,
  input  wire logic [CASE_W-1:0] case_select,
  input  wire logic              standby_request_input,
  input  wire logic              link_standby_cmd,
  input  wire logic              partner_park_standby,
  output logic                   safety_switch_output,
  output logic                   laser_enable,
  output logic                   park_standby_state,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  logic [2:0]        mode_ff;
  logic              shared_ff, link_en_ff;
  logic [NCASE-1:0]  defined_ff;
  logic [CASE_W-1:0] tbl_idx_ff;
  logic [IRQ_W-1:0]  irq_stat_ff, irq_en_ff, nxt_irq_stat, irq_ev;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  wire  wr_ctrl = reg_req.wr && (reg_req.addr == OFS_CTRL);
  wire  wr_def  = reg_req.wr && (reg_req.addr == OFS_DEFINED);
  wire  wr_idx  = reg_req.wr && (reg_req.addr == OFS_TBL_IDX);
  wire  wr_tbl  = reg_req.wr && (reg_req.addr == OFS_TBL_DATA);
  wire  wr_clr  = reg_req.wr && (reg_req.addr == OFS_IRQ_CLR);
  wire  wr_en   = reg_req.wr && (reg_req.addr == OFS_IRQ_EN);
  wire  clr_fault = wr_ctrl && reg_req.wdata[CTRL_CLRF_BIT];

  // Software-written configuration
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_ff    <= SEQ_ARBITRARY;
      shared_ff  <= 1'b0;
      link_en_ff <= 1'b0;
      defined_ff <= DEFINED_RST;
      tbl_idx_ff <= '0;
      irq_en_ff  <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_ff    <= reg_req.wdata[CTRL_MODE_LSB +: 3];
        shared_ff  <= reg_req.wdata[CTRL_SHARED_BIT];
        link_en_ff <= reg_req.wdata[CTRL_LINK_BIT];
      end
      if (wr_def)
        defined_ff <= reg_req.wdata[NCASE-1:0];
      if (wr_idx)
        tbl_idx_ff <= reg_req.wdata[CASE_W-1:0];
      if (wr_en)
        irq_en_ff <= reg_req.wdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Case table: per-case scan count, park mark and successors
  // ----------------------------------------------------------------
  logic [CASE_W-1:0] active_case_ff;
  case_entry_s       act_e, tbl_e;

  case_table #(.N(NCASE)) u_table (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .wr_en   (wr_tbl),
    .wr_idx  (tbl_idx_ff),
    .wr_data (case_entry_s'(reg_req.wdata[$bits(case_entry_s)-1:0])),
    .a_idx   (active_case_ff),
    .a_q     (act_e),
    .b_idx   (tbl_idx_ff),
    .b_q     (tbl_e)
  );

  // ----------------------------------------------------------------
  // Detection filter
  // ----------------------------------------------------------------
  logic [4:0] det_cnt_ff, nxt_det_cnt, eff_limit;
  logic       field_off;

  // clamp to range; an out-of-range entry can never weaken the filter below 2
  assign eff_limit = (act_e.scans < MIN_SCANS) ? MIN_SCANS :
                     (act_e.scans > MAX_SCANS) ? MAX_SCANS : act_e.scans;
  assign field_off = (det_cnt_ff >= eff_limit);
  assign nxt_det_cnt = !scan_strobe ? det_cnt_ff :
                       !scan_hit    ? 5'h00 :
                       (det_cnt_ff < MAX_SCANS) ? det_cnt_ff + 5'h01 : det_cnt_ff;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      det_cnt_ff <= 5'h00;
    else
      det_cnt_ff <= nxt_det_cnt;
  end

  // ----------------------------------------------------------------
  // Case selection and sequence check
  // ----------------------------------------------------------------
  logic upd_ff, seq_fault_ff;
  wire  undef   = !case_valid || !defined_ff[case_select];
  // Table read lags one cycle after a change, so a second change waits for fresh successors
  wire  chg_req = !undef && (case_select != active_case_ff) && !upd_ff;
  wire  is_a    = (case_select == act_e.succ_a);
  wire  is_b    = (case_select == act_e.succ_b);
  wire  allowed = (mode_ff == SEQ_UNIQUE) ? is_a :
                  (mode_ff == SEQ_ALT)    ? (is_a || is_b) : 1'b1;
  wire  accept  = chg_req && allowed;
  wire  violate = chg_req && !allowed;

  // fault latch; a new violation wins over a software clear
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      active_case_ff <= '0;
      upd_ff         <= 1'b0;
      seq_fault_ff   <= 1'b0;
    end
    else
    begin
      if (accept)
        active_case_ff <= case_select;
      upd_ff       <= accept;
      seq_fault_ff <= violate || (seq_fault_ff && !clr_fault);
    end
  end

  // ----------------------------------------------------------------
  // Operating state: run, park, wake from park, stand-by
  // ----------------------------------------------------------------
  op_state_e   state_ff, nxt_state;
  logic [15:0] wake_cnt_ff;
  // stand-by sources; handled apart from the case table
  wire standby = standby_request_input || (link_en_ff && link_standby_cmd);
  wire park_req = act_e.park && !upd_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN:
        if (standby)
          nxt_state = ST_STANDBY;
        else if (park_req)
          nxt_state = ST_PARK;
      ST_PARK:
        if (standby)
          nxt_state = ST_STANDBY;
        else if (!act_e.park && !upd_ff)
          nxt_state = ST_WAKE;
      ST_WAKE:
        if (standby)
          nxt_state = ST_STANDBY;
        else if (park_req)
          nxt_state = ST_PARK;
        else if (wake_cnt_ff <= 16'h0001)
          nxt_state = ST_RUN;
      ST_STANDBY:
        if (!standby)
          nxt_state = park_req ? ST_PARK : ST_RUN;
      default:
        nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff    <= ST_RUN;
      wake_cnt_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      if ((state_ff != ST_WAKE) && (nxt_state == ST_WAKE))
        wake_cnt_ff <= 16'(PARK_EXIT_CYCLES);
      else if (wake_cnt_ff != 16'h0000)
        wake_cnt_ff <= wake_cnt_ff - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Safety outputs
  // ----------------------------------------------------------------
  logic out_ff, laser_ff, ps_ff;
  wire  own_ps  = (state_ff == ST_PARK) || (state_ff == ST_STANDBY);
  // shared outputs follow partner; separate outputs ignore it
  wire  partner_off = shared_ff && partner_park_standby;
  wire  trip = field_off || seq_fault_ff || undef || partner_off || standby || (state_ff != ST_RUN);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_ff   <= 1'b0;
      laser_ff <= 1'b0;
      ps_ff    <= 1'b0;
    end
    else
    begin
      out_ff   <= !trip;
      laser_ff <= !own_ps;
      ps_ff    <= own_ps;
    end
  end

  assign safety_switch_output = out_ff;
  assign laser_enable         = laser_ff;
  assign park_standby_state   = ps_ff;

  // ----------------------------------------------------------------
  // Interrupts and read-back
  // ----------------------------------------------------------------
  assign irq_ev[IRQ_SEQ]     = violate;
  assign irq_ev[IRQ_UNDEF]   = undef;
  assign irq_ev[IRQ_TRIP]    = out_ff && trip;
  assign irq_ev[IRQ_PARKSTB] = !own_ps && ((nxt_state == ST_PARK) || (nxt_state == ST_STANDBY));
  // Set wins over a clear in the same cycle
  assign nxt_irq_stat = (irq_stat_ff & ~(wr_clr ? reg_req.wdata[IRQ_W-1:0] : '0)) | irq_ev;
  assign irq = |(irq_stat_ff & irq_en_ff);

  always_comb
  begin
    nxt_rdata = '0;
    if (reg_req.rd)
      case (reg_req.addr)
        OFS_CTRL:     nxt_rdata = {26'h0, link_en_ff, shared_ff, 1'b0, mode_ff};
        OFS_DEFINED:  nxt_rdata = {16'h0, defined_ff};
        OFS_TBL_IDX:  nxt_rdata = {28'h0, tbl_idx_ff};
        OFS_TBL_DATA: nxt_rdata = {18'h0, tbl_e};
        OFS_STATUS:   nxt_rdata = {15'h0, laser_ff, out_ff, undef, seq_fault_ff, state_ff, det_cnt_ff, active_case_ff};
        OFS_IRQ_STAT: nxt_rdata = {28'h0, irq_stat_ff};
        OFS_IRQ_EN:   nxt_rdata = {28'h0, irq_en_ff};
        default:      nxt_rdata = '0;
      endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_stat_ff <= '0;
      rdata_ff    <= '0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_limit_range;
    eff_limit >= MIN_SCANS && eff_limit <= MAX_SCANS;
  endproperty
  a_limit_range: assert property (p_limit_range) else $error("scan limit out of range");

  property p_clear_scan;
    scan_strobe && !scan_hit |=> det_cnt_ff == 5'h00 && !field_off;
  endproperty
  a_clear_scan: assert property (p_clear_scan) else $error("counter not restarted");

  property p_trip_run;
    scan_strobe && scan_hit && !upd_ff && (det_cnt_ff == eff_limit - 5'h01) |=> ##1 !safety_switch_output;
  endproperty
  a_trip_run: assert property (p_trip_run) else $error("no trip after full run");

  // One hit advances the run by exactly one, so a trip always needs the full run
  property p_no_early_trip;
    scan_strobe && scan_hit && (det_cnt_ff < MAX_SCANS) |=> det_cnt_ff == $past(det_cnt_ff) + 5'h01;
  endproperty
  a_no_early_trip: assert property (p_no_early_trip) else $error("early trip");

  property p_unique;
    (mode_ff == SEQ_UNIQUE) && chg_req && !is_a |=> seq_fault_ff && $stable(active_case_ff) ##1 !safety_switch_output;
  endproperty
  a_unique: assert property (p_unique) else $error("unique sequence not enforced");

  property p_alt;
    (mode_ff == SEQ_ALT) && chg_req && (is_a || is_b) |=> active_case_ff == $past(case_select) && !violate;
  endproperty
  a_alt: assert property (p_alt) else $error("alternative successor refused");

  property p_park_off;
    own_ps |=> !safety_switch_output && !laser_enable && park_standby_state;
  endproperty
  a_park_off: assert property (p_park_off) else $error("park or stand-by left outputs on");

  property p_standby_in;
    standby_request_input |=> !safety_switch_output && (state_ff == ST_STANDBY);
  endproperty
  a_standby_in: assert property (p_standby_in) else $error("stand-by input ignored");

  property p_shared;
    shared_ff && partner_park_standby |=> !safety_switch_output;
  endproperty
  a_shared: assert property (p_shared) else $error("shared outputs stayed on");

  property p_wake;
    (state_ff == ST_PARK) && (nxt_state == ST_WAKE) |=> !safety_switch_output [*2];
  endproperty
  a_wake: assert property (p_wake) else $error("park exit too fast");

  property p_undef;
    !case_valid |=> !safety_switch_output;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined case kept outputs on");

  c_trip:    cover property (scan_strobe && scan_hit ##1 field_off);
  c_park:    cover property ((state_ff == ST_PARK) ##[1:20] (state_ff == ST_WAKE));
  c_seqerr:  cover property (violate ##1 irq);
  c_standby: cover property (link_en_ff && link_standby_cmd ##1 (state_ff == ST_STANDBY));

endmodule

// *** shared/supervisor_pkg.sv ***
// Shared constants, types and register map for the monitoring case supervisor
package supervisor_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCASE  = 16;
  localparam int CASE_W = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Consecutive-detection limits and table reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]       MIN_SCANS   = 5'h02;
  localparam logic [4:0]       MAX_SCANS   = 5'h10;
  localparam logic [4:0]       RST_SCANS   = 5'h02;
  localparam logic [NCASE-1:0] DEFINED_RST = 16'hffff;

  // ----------------------------------------------------------------
  // Timing: delay when leaving park for another case
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 8;
  localparam int PARK_EXIT_NS  = 80000;
  localparam int PARK_EXIT_CYC = (PARK_EXIT_NS / CLK_NS) < 1 ? 1 : (PARK_EXIT_NS / CLK_NS);

  // ----------------------------------------------------------------
  // Register offsets (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DEFINED  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_TBL_IDX  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_TBL_DATA = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 4'h7;

  // Control field positions
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_SHARED_BIT = 3;
  localparam int CTRL_LINK_BIT   = 4;
  localparam int CTRL_CLRF_BIT   = 5;

  // Status field positions
  localparam int ST_CASE_LSB  = 0;
  localparam int ST_CNT_LSB   = 4;
  localparam int ST_STATE_LSB = 9;
  localparam int ST_FAULT_BIT = 13;
  localparam int ST_UNDEF_BIT = 14;
  localparam int ST_OUT_BIT   = 15;
  localparam int ST_LASER_BIT = 16;

  // Interrupt bits
  localparam int IRQ_W       = 4;
  localparam int IRQ_SEQ     = 0;
  localparam int IRQ_UNDEF   = 1;
  localparam int IRQ_TRIP    = 2;
  localparam int IRQ_PARKSTB = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_ARBITRARY = 3'b001,
    SEQ_UNIQUE    = 3'b010,
    SEQ_ALT       = 3'b100
  } seq_mode_e;

  typedef enum logic [3:0] {
    ST_RUN     = 4'b0001,
    ST_PARK    = 4'b0010,
    ST_WAKE    = 4'b0100,
    ST_STANDBY = 4'b1000
  } op_state_e;

  typedef struct packed {
    logic [CASE_W-1:0] succ_b;
    logic [CASE_W-1:0] succ_a;
    logic              park;
    logic [4:0]        scans;
  } case_entry_s;

  localparam case_entry_s ENTRY_RST = '{succ_b: 4'h0, succ_a: 4'h0, park: 1'b0, scans: RST_SCANS};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

endpackage

// *** design/case_table.sv ***
// Per-case configuration table with one write port and two registered read ports
`timescale 1ns/1ps
module case_table
  import supervisor_pkg::*;
#(
  parameter int N = NCASE
)(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              wr_en,
  input  wire logic [CASE_W-1:0] wr_idx,
  input  wire case_entry_s       wr_data,
  input  wire logic [CASE_W-1:0] a_idx,
  output case_entry_s            a_q,
  input  wire logic [CASE_W-1:0] b_idx,
  output case_entry_s            b_q
);

  case_entry_s mem_ff [N];

  // ----------------------------------------------------------------
  // Storage, one entry per monitoring case
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N; i++)
  begin : g_entry
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
        mem_ff[i] <= ENTRY_RST;
      else if (wr_en && (wr_idx == CASE_W'(i)))
        mem_ff[i] <= wr_data;
    end
  end

  // Registered read ports: one follows the active case, one serves software
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      a_q <= ENTRY_RST;
      b_q <= ENTRY_RST;
    end
    else
    begin
      a_q <= mem_ff[a_idx];
      b_q <= mem_ff[b_idx];
    end
  end

endmodule

// *** verif/safety_controller_model.sv ***
// Machine controller model: issues stand-by requests and watches the outputs
`timescale 1ns/1ps
module safety_controller_model
#(
  parameter int LAG = 1 // Reaction delay in cycles, 1..8
)(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic want_standby,
  input  wire logic want_link,
  input  wire logic safety_switch_output,
  output logic      standby_request_input,
  output logic      link_standby_cmd,
  output int        trip_cnt_ff
);
  // ----------------------------------------------------------------
  // Request pipeline
  // ----------------------------------------------------------------
  logic [7:0] standby_ff;
  logic [7:0] link_ff;
  logic       out_ff;

  // controller drives requests
  // A slow controller is modelled by a longer LAG
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      standby_ff <= 8'h00;
      link_ff <= 8'h00;
      out_ff <= 1'b0;
      trip_cnt_ff <= 0;
    end
    else
    begin
      standby_ff <= {standby_ff[6:0], want_standby};
      link_ff <= {link_ff[6:0], want_link};
      out_ff <= safety_switch_output;
      if (out_ff && !safety_switch_output)
        trip_cnt_ff <= trip_cnt_ff + 1;
    end
  end

  assign standby_request_input = standby_ff[LAG-1];
  assign link_standby_cmd = link_ff[LAG-1];
endmodule

// *** verif/monitoring_case_supervisor_bench.sv ***
// Self-checking bench of the monitoring case supervisor
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module monitoring_case_supervisor_bench;
  import supervisor_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int EXIT = 4; // Short park exit keeps the run brief
  logic              ref_clk;
  logic              resetn;
  reg_req_s          reg_req;
  logic [DATA_W-1:0] reg_rdata;
  logic              strobe;
  logic              hit;
  logic              cvalid;
  logic [3:0]        csel;
  logic              standby_in;
  logic              lcmd;
  logic              want_standby;
  logic              want_link;
  logic              partner;
  logic              out;
  logic              laser;
  logic              pstate;
  logic              irq;
  int                trips;
  int                num_errors;
  int                n_compared;
  int                cycles;
  logic [DATA_W-1:0] v;

  monitoring_case_supervisor #(.PARK_EXIT_CYCLES(EXIT)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .scan_strobe(strobe), .scan_hit(hit), .case_valid(cvalid), .case_select(csel),
    .standby_request_input(standby_in), .link_standby_cmd(lcmd),
    .partner_park_standby(partner), .safety_switch_output(out),
    .laser_enable(laser), .park_standby_state(pstate), .irq(irq));

  safety_controller_model i_ctl (
    .ref_clk(ref_clk), .resetn(resetn), .want_standby(want_standby), .want_link(want_link),
    .safety_switch_output(out), .standby_request_input(standby_in),
    .link_standby_cmd(lcmd), .trip_cnt_ff(trips));

  // ----------------------------------------------------------------
  // Clock, timeout and bus tasks
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Whole sequence needs a few hundred cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    `CHK(v, e)
  endtask

  task automatic chk_case(input logic [3:0] c);
    rd(OFS_STATUS);
    `CHK(v[3:0], c)
  endtask

  task automatic ent(input logic [3:0] i, input logic [4:0] s, input logic p, input logic [3:0] a,
                     input logic [3:0] b);
    wr(OFS_TBL_IDX, {28'h0, i});
    wr(OFS_TBL_DATA, 32'(case_entry_s'{succ_b: b, succ_a: a, park: p, scans: s}));
  endtask

  task automatic scan(input logic h);
    @(posedge ref_clk);
    strobe <= 1'b1;
    hit <= h;
    @(posedge ref_clk);
    strobe <= 1'b0;
  endtask

  task automatic sel(input logic [3:0] c);
    @(posedge ref_clk);
    csel <= c;
    cyc(3);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Limits include out-of-range settings, which clamp to 2 and 16
  task automatic t_filter();
    logic [4:0] cfg [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f};
    int         lim [6] = '{2, 2, 4, 8, 16, 16};
    for (int i = 0; i < 6; i++)
    begin
      ent(4'h0, cfg[i], 1'b0, 4'h0, 4'h0);
      repeat (lim[i] - 1) scan(1'b1);
      scan(1'b0);
      repeat (lim[i] - 1) scan(1'b1);
      cyc(3);
      `CHK(out, 1'b1)
      scan(1'b1);
      cyc(2);
      `CHK(out, 1'b0)
      scan(1'b0);
      cyc(3);
      `CHK(out, 1'b1)
    end
  endtask

  task automatic t_percase();
    ent(4'h0, 5'h02, 1'b0, 4'h0, 4'h0);
    ent(4'h5, 5'h04, 1'b0, 4'h7, 4'h0);
    sel(4'h5);
    repeat (3) scan(1'b1);
    cyc(3);
    `CHK(out, 1'b1)
    scan(1'b1);
    cyc(2);
    `CHK(out, 1'b0)
    scan(1'b0);
  endtask

  // Violations trip the outputs until software clears the fault
  task automatic t_seq();
    wr(OFS_CTRL, 32'(SEQ_UNIQUE));
    sel(4'h9);
    `CHK(out, 1'b0)
    rd(OFS_STATUS);
    `CHK(v[ST_FAULT_BIT], 1'b1)
    chk_case(4'h5);
    sel(4'h5);
    wr(OFS_CTRL, 32'(SEQ_UNIQUE) | 32'h20);
    cyc(2);
    `CHK(out, 1'b1)
    sel(4'h7);
    chk_case(4'h7);
    ent(4'h7, 5'h02, 1'b0, 4'h1, 4'h2);
    wr(OFS_CTRL, 32'(SEQ_ALT));
    sel(4'h2);
    chk_case(4'h2);
    sel(4'h3);
    `CHK(out, 1'b0)
    sel(4'h2);
    wr(OFS_CTRL, 32'(SEQ_ARBITRARY) | 32'h20);
    sel(4'hb);
    chk_case(4'hb);
    `CHK(out, 1'b1)
  endtask

  task automatic t_undef();
    @(posedge ref_clk);
    cvalid <= 1'b0;
    cyc(3);
    `CHK(out, 1'b0)
    @(posedge ref_clk);
    cvalid <= 1'b1;
    wr(OFS_DEFINED, 32'h0000efff);
    sel(4'hc);
    `CHK(out, 1'b0)
    sel(4'hb);
    wr(OFS_DEFINED, 32'h0000ffff);
    cyc(2);
    `CHK(out, 1'b1)
  endtask

  task automatic t_park();
    ent(4'h3, 5'h02, 1'b1, 4'h0, 4'h0);
    sel(4'h3);
    cyc(1);
    `CHK(out, 1'b0)
    `CHK(laser, 1'b0)
    `CHK(pstate, 1'b1)
    sel(4'h4);
    `CHK(out, 1'b0)
    cyc(EXIT - 2);
    `CHK(out, 1'b0)
    cyc(5);
    `CHK(out, 1'b1)
    `CHK(laser, 1'b1)
  endtask

  task automatic t_standby();
    @(posedge ref_clk);
    want_standby <= 1'b1;
    cyc(4);
    `CHK(out, 1'b0)
    `CHK(laser, 1'b0)
    `CHK(pstate, 1'b1)
    chk_case(4'h4);
    @(posedge ref_clk);
    want_standby <= 1'b0;
    cyc(4);
    `CHK(out, 1'b1)
    @(posedge ref_clk);
    want_link <= 1'b1;
    cyc(4);
    `CHK(out, 1'b1)
    wr(OFS_CTRL, 32'(SEQ_ARBITRARY) | 32'h10);
    cyc(2);
    `CHK(out, 1'b0)
    @(posedge ref_clk);
    want_link <= 1'b0;
    cyc(4);
    `CHK(out, 1'b1)
  endtask

  task automatic t_pair();
    @(posedge ref_clk);
    partner <= 1'b1;
    cyc(3);
    `CHK(out, 1'b1)
    wr(OFS_CTRL, 32'(SEQ_ARBITRARY) | 32'h18);
    cyc(2);
    `CHK(out, 1'b0)
    @(posedge ref_clk);
    partner <= 1'b0;
    cyc(3);
    `CHK(out, 1'b1)
  endtask

  // Every event kind has occurred by now
  task automatic t_irq();
    rchk(OFS_IRQ_STAT, 32'h0000000f);
    wr(OFS_IRQ_EN, 32'h4);
    cyc(1);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_CLR, 32'hf);
    cyc(1);
    `CHK(irq, 1'b0)
    scan(1'b1);
    scan(1'b1);
    cyc(3);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_EN, 32'h0);
    cyc(1);
    `CHK(irq, 1'b0)
    scan(1'b0);
    rchk(4'h9, 32'h0);
    rchk(OFS_IRQ_CLR, 32'h0);
    `CHK(trips > 0, 1'b1)
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    reg_req = '0;
    {strobe, hit, csel, want_standby, want_link, partner} = '0;
    cvalid = 1'b1;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    cyc(3);
    `CHK({out, laser, pstate, irq}, 4'h0)
    resetn = 1'b1;
    cyc(3);
    `CHK({out, laser}, 2'b11)
    rchk(OFS_DEFINED, 32'h0000ffff);
    rchk(OFS_CTRL, 32'h00000001);
    t_filter();
    t_percase();
    t_seq();
    t_undef();
    t_park();
    t_standby();
    t_pair();
    t_irq();
    end_sim();
  end
endmodule
